// ==== hdl/kpsc_pkg.sv ====
// Purpose: Shared constants and types for the keypad scan order and interrupt block
// Assumes: Registers are 8 bits wide, each in the low byte of one Wishbone word
// Notes: Register indices are word indices; the byte address is four times the index
package kpsc_pkg;

  // Wishbone address width and register index width
  localparam int WB_ADR_W = 18;
  localparam int IDX_W = 16;

  // Register indices
  localparam logic [IDX_W-1:0] IDX_KEYPAD_SIZE = 16'h00d5;
  localparam logic [IDX_W-1:0] IDX_COL_ORDER_LOW = 16'h00d6;
  localparam logic [IDX_W-1:0] IDX_COL_ORDER_HIGH = 16'h00d7;
  localparam logic [IDX_W-1:0] IDX_KP_IRQ_CONTROL = 16'hff94;
  localparam logic [IDX_W-1:0] IDX_SCAN_CONTROL = 16'h00e0;
  localparam logic [IDX_W-1:0] IDX_KEY_LOCATION = 16'h00e1;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 16'h00e2;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'h00e3;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [4:0] COL_ALL_OFF = 5'h1f;

  // Field layout: keypad_size, and the write mask of column order high
  localparam int COL_COUNT_LSB = 0;
  localparam int ROW_COUNT_LSB = 3;
  localparam logic [7:0] KEYPAD_SIZE_MASK = 8'h3f;
  localparam logic [7:0] COL_ORDER_HIGH_MASK = 8'h7f;

  // Field layout: keypad_interrupt_control
  localparam int KP_IRQ_FLAG_BIT = 0;
  localparam int KP_IRQ_ENABLE_BIT = 1;
  localparam int POWERDOWN_MUX_SELECT_SELECT_BIT = 7;

  // Field layout: scan_control
  localparam int AUTO_SCAN_ON_BIT = 0;
  localparam int MANUAL_COL_LSB = 1;
  localparam int KEY_FOUND_BIT = 7;

  // Field layout: key_location
  localparam int KEY_COL_LSB = 0;
  localparam int KEY_ROW_LSB = 3;

  // Event bits of irq_status and irq_mask
  localparam int EV_KEY_FOUND = 0;
  localparam int EV_KEY_RELEASED = 1;
  localparam int NUM_EVENTS = 2;

  // Matrix geometry
  localparam int MAX_ROWS = 6;
  localparam int MAX_COLS = 5;
  localparam int SLOT_W = 3;
  localparam int NUM_SLOTS = 5;

  typedef enum logic [2:0] {
    KPSC_IDLE = 3'b001,
    KPSC_SCAN = 3'b010,
    KPSC_HOLD = 3'b100
  } kpsc_state_type;

endpackage

// ==== hdl/kpsc_sticky.sv ====
// Purpose: One sticky event flag, set by hardware, cleared by software
// Assumes: Set and clear are single-cycle strobes in the clk_i domain
// Notes: A set in the clearing cycle wins so that no event is lost
`timescale 1ns/1ns
module kpsc_sticky (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);

  logic flag_next;

  assign flag_next = set_i | (flag_o & ~clr_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= flag_next;
    end
  end

endmodule

// ==== hdl/kpsc_col_decode.sv ====
// Purpose: Turn a binary column number into a one-hot column select
// Assumes: Numbers at or above COLS select no column
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ns
module kpsc_col_decode #(
  parameter int COLS = 5
) (
  input wire logic [2:0] index_i,
  input wire logic enable_i,
  output logic [COLS-1:0] onehot_o
);

  genvar i;
  generate
    for (i = 0; i < COLS; i++) begin : g_col
      assign onehot_o[i] = enable_i & (index_i == 3'(i));
    end
  endgenerate

endmodule

// ==== hdl/kpsc_top.sv ====
// Purpose: Keypad scan size, column order and keypad interrupt registers with scanner
// Assumes: Wishbone classic slave; rows active low, columns driven low to select
// Notes: scan_tick_i is the 1 kHz scan strobe, one clk_i cycle wide
//
// Contract
// R1: Size fields ignored while auto scan off
// R2: Row count field limits scanned rows, max 6
// R3: Column count field limits scanned columns, max 5
// R4: Five three-bit order slots over two registers
// R5: Step slots from first up to column count
// R6: Values 0..4 give plain sequential scan
// R7: Firmware reloads order inside keypad interrupt handler
// R8: Slot values are binary column numbers
// R9: Third slot split: low bits low, msb high bit0
// R10: Slots four, five in high bits 3:1, 6:4
// R11: Keypad interrupt forwarded only when enable set
// R12: Keypad flag set by key found, clear on read
// R13: Bit 7 is read/write power-down mux select
// R14: Auto scan on scans; off bypasses to firmware
// R15: Key found flag on valid press, clear on read
// R16: Registers reset to zero, unused bits read zero
`timescale 1ns/1ns
module kpsc_top
  import kpsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [WB_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic scan_tick_i,
  input wire logic [MAX_ROWS-1:0] row_n_i,
  output logic [MAX_COLS-1:0] col_drive_n_o,
  output logic powerdown_mux_select_o,
  output logic irq_o
);

  // Register file
  logic [7:0] keypad_size_reg;
  logic [7:0] column_order_low_reg;
  logic [7:0] column_order_high_reg;
  logic keypad_irq_enable_reg;
  logic powerdown_mux_select_reg;
  logic auto_scan_on_reg;
  logic [MAX_COLS-1:0] manual_col_reg;
  logic [NUM_EVENTS-1:0] irq_mask_reg;
  logic [2:0] key_row_reg;
  logic [2:0] key_col_reg;
  // Scanner state
  kpsc_state_type state_reg;
  kpsc_state_type state_next;
  logic [2:0] slot_ptr_reg;
  logic [2:0] slot_ptr_next;
  logic rows_high_reg;
  // Bus decode
  wire [IDX_W-1:0] reg_index = adr_i[WB_ADR_W-1:2];
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire bus_wr = bus_req & we_i & sel_i[0];
  wire bus_rd = bus_req & ~we_i;
  wire hit_size = reg_index == IDX_KEYPAD_SIZE;
  wire hit_order_lo = reg_index == IDX_COL_ORDER_LOW;
  wire hit_order_hi = reg_index == IDX_COL_ORDER_HIGH;
  wire hit_intctl = reg_index == IDX_KP_IRQ_CONTROL;
  wire hit_scanctl = reg_index == IDX_SCAN_CONTROL;
  wire hit_keyloc = reg_index == IDX_KEY_LOCATION;
  wire hit_status = reg_index == IDX_IRQ_STATUS;
  wire hit_mask = reg_index == IDX_IRQ_MASK;
  wire [7:0] wr_byte = dat_i[7:0];
  // Size fields and their clamped forms
  wire [2:0] column_count = keypad_size_reg[COL_COUNT_LSB +: 3];
  wire [2:0] row_count = keypad_size_reg[ROW_COUNT_LSB +: 3];
  wire [2:0] eff_cols = (column_count > 3'(MAX_COLS)) ? 3'(MAX_COLS) : column_count; // R3
  wire [2:0] eff_rows = (row_count > 3'(MAX_ROWS)) ? 3'(MAX_ROWS) : row_count; // R2
  // Order slots; the third straddles both registers
  wire [SLOT_W-1:0] slot_val [NUM_SLOTS];
  assign slot_val[0] = column_order_low_reg[2:0]; // R4
  assign slot_val[1] = column_order_low_reg[5:3]; // R4
  assign slot_val[2] = {column_order_high_reg[0], column_order_low_reg[7:6]}; // R9
  assign slot_val[3] = column_order_high_reg[3:1]; // R10
  assign slot_val[4] = column_order_high_reg[6:4]; // R10
  wire [SLOT_W-1:0] cur_slot = slot_val[slot_ptr_reg];
  // Row sensing limited to the configured rows
  logic [MAX_ROWS-1:0] row_enable;
  genvar r;
  generate
    for (r = 0; r < MAX_ROWS; r++) begin : g_row
      assign row_enable[r] = 3'(r) < eff_rows; // R2
    end
  endgenerate
  wire [MAX_ROWS-1:0] row_active = ~row_n_i & row_enable;
  wire row_hit = |row_active;
  wire rows_all_high = &row_n_i;
  logic [2:0] hit_row;
  always_comb begin
    hit_row = 3'h0;
    for (int i = MAX_ROWS - 1; i >= 0; i--) begin
      if (row_active[i]) begin
        hit_row = 3'(i);
      end
    end
  end
  wire in_idle = state_reg == KPSC_IDLE;
  wire in_scan = state_reg == KPSC_SCAN;
  wire in_hold = state_reg == KPSC_HOLD;
  wire scan_ok = auto_scan_on_reg & (eff_cols != 3'h0); // R1 R14
  wire scan_capture = in_scan & scan_tick_i & row_hit; // R15
  wire scan_miss = in_scan & scan_tick_i & ~row_hit;
  wire scan_release = in_hold & scan_tick_i & ~row_hit;
  // Bypass: any row falling after all rows were high; bounces may repeat it
  wire bypass_press = in_idle & ~auto_scan_on_reg & rows_high_reg & ~rows_all_high; // R14
  wire key_found_set = scan_capture | bypass_press;
  wire [2:0] ptr_inc = slot_ptr_reg + 3'h1;
  wire [2:0] ptr_step = (ptr_inc >= eff_cols) ? 3'h0 : ptr_inc; // R5 R6
  // Scanner state machine
  always_comb begin
    state_next = state_reg;
    slot_ptr_next = slot_ptr_reg;
    case (state_reg)
      KPSC_IDLE: begin
        slot_ptr_next = 3'h0;
        if (scan_ok) begin
          state_next = KPSC_SCAN;
        end
      end
      KPSC_SCAN: begin
        if (!scan_ok) begin
          state_next = KPSC_IDLE;
        end else if (scan_capture) begin
          state_next = KPSC_HOLD;
        end else if (scan_miss) begin
          slot_ptr_next = ptr_step; // R5
        end
      end
      KPSC_HOLD: begin
        if (!scan_ok) begin
          state_next = KPSC_IDLE;
        end else if (scan_release) begin
          state_next = KPSC_SCAN;
          slot_ptr_next = ptr_step;
        end
      end
      default: begin
        state_next = KPSC_IDLE;
        slot_ptr_next = 3'h0;
      end
    endcase
  end
  // Column drive: slot decode when scanning, firmware pattern in bypass
  logic [MAX_COLS-1:0] slot_onehot;
  kpsc_col_decode #(
    .COLS(MAX_COLS)
  ) u_col_decode (
    .index_i(cur_slot),
    .enable_i(~in_idle),
    .onehot_o(slot_onehot)
  );
  wire [MAX_COLS-1:0] col_drive_n_next = in_idle ? ~manual_col_reg : ~slot_onehot; // R5 R8 R14

  // Sticky flags
  logic key_found_flag;
  logic keypad_irq_flag;
  logic [NUM_EVENTS-1:0] irq_status;
  wire [NUM_EVENTS-1:0] event_set = {scan_release, key_found_set};

  kpsc_sticky u_key_found (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(key_found_set), // R15
    .clr_i(bus_rd & hit_scanctl), // R15
    .flag_o(key_found_flag)
  );

  kpsc_sticky u_kp_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(key_found_set), // R12
    .clr_i(bus_rd & hit_intctl), // R12
    .flag_o(keypad_irq_flag)
  );

  genvar e;
  generate
    for (e = 0; e < NUM_EVENTS; e++) begin : g_event
      kpsc_sticky u_event (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(event_set[e]),
        .clr_i(bus_wr & hit_status & wr_byte[e]),
        .flag_o(irq_status[e])
      );
    end
  endgenerate

  // R7 is firmware's duty; a reload during a hold moves the driven column one clk_i edge after the register is written
  wire irq_next = (keypad_irq_flag & keypad_irq_enable_reg) | (|(irq_status & irq_mask_reg)); // R11

  // Read data; unused bits and unmapped addresses read as zero
  wire [7:0] rd_intctl = {powerdown_mux_select_reg, 5'h00, keypad_irq_enable_reg, keypad_irq_flag};
  wire [7:0] rd_scanctl = {key_found_flag, 1'b0, manual_col_reg, auto_scan_on_reg};
  wire [7:0] rd_keyloc = {2'h0, key_row_reg, key_col_reg};
  wire [7:0] rd_byte =
    hit_size ? keypad_size_reg :
    hit_order_lo ? column_order_low_reg :
    hit_order_hi ? column_order_high_reg :
    hit_intctl ? rd_intctl :
    hit_scanctl ? rd_scanctl :
    hit_keyloc ? rd_keyloc :
    hit_status ? {6'h00, irq_status} :
    hit_mask ? {6'h00, irq_mask_reg} : 8'h00; // R16

  // Bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Software-written registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keypad_size_reg <= RST_REG; // R16
      column_order_low_reg <= RST_REG;
      column_order_high_reg <= RST_REG;
      keypad_irq_enable_reg <= 1'b0;
      powerdown_mux_select_reg <= 1'b0;
      auto_scan_on_reg <= 1'b0;
      manual_col_reg <= RST_REG[MAX_COLS-1:0];
      irq_mask_reg <= RST_REG[NUM_EVENTS-1:0];
    end else if (bus_wr) begin
      if (hit_size) keypad_size_reg <= wr_byte & KEYPAD_SIZE_MASK; // R2 R3
      if (hit_order_lo) column_order_low_reg <= wr_byte; // R4
      if (hit_order_hi) column_order_high_reg <= wr_byte & COL_ORDER_HIGH_MASK; // R10
      if (hit_intctl) begin
        keypad_irq_enable_reg <= wr_byte[KP_IRQ_ENABLE_BIT]; // R11
        powerdown_mux_select_reg <= wr_byte[POWERDOWN_MUX_SELECT_SELECT_BIT]; // R13
      end
      if (hit_scanctl) begin
        auto_scan_on_reg <= wr_byte[AUTO_SCAN_ON_BIT]; // R14
        manual_col_reg <= wr_byte[MANUAL_COL_LSB +: MAX_COLS];
      end
      if (hit_mask) irq_mask_reg <= wr_byte[NUM_EVENTS-1:0];
    end
  end

  // Scanner registers and outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= KPSC_IDLE;
      slot_ptr_reg <= 3'h0;
      rows_high_reg <= 1'b1;
      key_row_reg <= 3'h0;
      key_col_reg <= 3'h0;
      col_drive_n_o <= COL_ALL_OFF;
      powerdown_mux_select_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      slot_ptr_reg <= slot_ptr_next;
      rows_high_reg <= rows_all_high;
      if (scan_capture) begin
        key_row_reg <= hit_row;
        key_col_reg <= cur_slot;
      end
      col_drive_n_o <= col_drive_n_next;
      powerdown_mux_select_o <= powerdown_mux_select_reg;
      irq_o <= irq_next;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence scan_step_s;
    in_scan && scan_ok && scan_miss;
  endsequence

  sequence press_s;
    key_found_set && !(bus_rd && hit_intctl);
  endsequence

  size_bypass_a: assert property (!auto_scan_on_reg |=> in_idle) // R1
    else $error("scanner left idle while auto scan off");
  row_limit_a: assert property (scan_capture |=> key_row_reg < eff_rows) // R2
    else $error("captured row beyond row count");
  col_limit_a: assert property (!in_idle |-> slot_ptr_reg < eff_cols) // R3
    else $error("slot pointer beyond column count");
  slot_drive_a: assert property (in_scan && cur_slot < 3'(MAX_COLS)
      |=> !col_drive_n_o[$past(cur_slot)] && $countones(~col_drive_n_o) == 1) // R4
    else $error("scanned column does not follow slot");
  slot_step_a: assert property (scan_step_s ##1 (in_scan && scan_ok)
      |-> slot_ptr_reg == $past(ptr_step)) // R5
    else $error("slot pointer did not step");
  seq_wrap_a: assert property (scan_step_s and (slot_ptr_reg == eff_cols - 3'h1)
      |=> slot_ptr_reg == 3'h0) // R6
    else $error("scan did not wrap to first slot");
  first_slot_a: assert property (in_scan && slot_ptr_reg == 3'h0 && slot_val[0] == 3'h0
      |=> !col_drive_n_o[0]) // R8
    else $error("first slot zero did not drive column zero");
  third_split_a: assert property (in_scan && slot_ptr_reg == 3'h2
      && {column_order_high_reg[0], column_order_low_reg[7:6]} == 3'h4
      |=> !col_drive_n_o[4]) // R9
    else $error("third slot msb not taken from high register");
  fifth_slot_a: assert property (in_scan && slot_ptr_reg == 3'h4
      && column_order_high_reg[6:4] < 3'(MAX_COLS)
      |=> !col_drive_n_o[$past(column_order_high_reg[6:4])]) // R10
    else $error("fifth slot not taken from high bits");
  irq_gate_a: assert property (!keypad_irq_enable_reg && !(|(irq_status & irq_mask_reg))
      |=> !irq_o) // R11
    else $error("keypad interrupt raised while disabled");
  irq_flag_a: assert property (press_s |=> keypad_irq_flag ##1 (irq_o || !keypad_irq_enable_reg)) // R11
    else $error("keypad flag not raised or not forwarded");
  flag_clear_a: assert property (bus_rd && hit_intctl && !key_found_set |=> !keypad_irq_flag) // R12
    else $error("keypad flag not cleared by read");
  powerdown_mux_select_rw_a: assert property (bus_wr && hit_intctl
      |=> powerdown_mux_select_reg == $past(wr_byte[POWERDOWN_MUX_SELECT_SELECT_BIT])
      ##1 powerdown_mux_select_o == powerdown_mux_select_reg) // R13
    else $error("power-down mux select not held");
  bypass_cols_a: assert property (in_idle && state_next == KPSC_IDLE
      |=> col_drive_n_o == ~$past(manual_col_reg)) // R14
    else $error("bypass column drive wrong");
  key_found_a: assert property (scan_capture && !(bus_rd && hit_scanctl)
      |=> key_found_flag && in_hold && key_col_reg == $past(cur_slot)) // R15
    else $error("valid press not recorded");
  reset_zero_a: assert property ($past(rst_i) |-> keypad_size_reg == 8'h00
      && column_order_low_reg == 8'h00 && column_order_high_reg == 8'h00
      && !keypad_irq_enable_reg && !keypad_irq_flag && !powerdown_mux_select_reg) // R16
    else $error("register not zero after reset");

endmodule

// ==== tb/kpsc_keypad_model.sv ====
// Purpose: Behavioural key matrix where one switch joins a row to a column
// Assumes: Rows have pull-ups; a column is selected while its drive is low
// Notes: Only one key is held at a time, which is all the bench needs
`timescale 1ns/1ns
module kpsc_keypad_model (
  input wire logic [4:0] col_drive_n_i,
  input wire logic press_i,
  input wire logic [2:0] row_sel_i,
  input wire logic [2:0] col_sel_i,
  output logic [5:0] row_n_o
);
  // A row that no driven column pulls down returns to the pull-up level
  always_comb begin
    row_n_o = 6'h3f;
    if (press_i && col_sel_i < 3'h5 && col_drive_n_i[col_sel_i] == 1'b0) begin
      row_n_o[row_sel_i] = 1'b0;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the keypad scan order and interrupt block
// Assumes: Classic Wishbone master; one key held at a time
// Notes: Expected values are worked out from the register layout
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  import kpsc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [WB_ADR_W-1:0] adr_i = 18'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic scan_tick_i = 1'b0;
  logic [MAX_ROWS-1:0] row_n_i;
  logic [MAX_COLS-1:0] col_drive_n_o;
  logic powerdown_mux_select_o;
  logic irq_o;
  logic press = 1'b0;
  logic [2:0] krow = 3'h0;
  logic [2:0] kcol = 3'h0;
  logic [2:0] ord [5];
  logic [7:0] q;
  logic [7:0] v;
  logic hit;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 5616;
  always #20 clk_i = ~clk_i;
  kpsc_top i_kpsc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .scan_tick_i(scan_tick_i), .row_n_i(row_n_i), .col_drive_n_o(col_drive_n_o),
    .powerdown_mux_select_o(powerdown_mux_select_o), .irq_o(irq_o));
  kpsc_keypad_model i_kpsc_keypad_model (.col_drive_n_i(col_drive_n_o), .press_i(press),
    .row_sel_i(krow), .col_sel_i(kcol), .row_n_o(row_n_i));
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One classic cycle; the request stands until the edge that samples ack
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'h1;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("MISMATCH t=%0t no bus answer", $time);
      close_out();
    end
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
  endtask
  task automatic chk_rd(input logic [15:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    `CHK(q, e)
  endtask
  // Ticks stay well apart; three edges let flags reach irq_o
  task automatic tick();
    @(posedge clk_i);
    scan_tick_i <= 1'b1;
    @(posedge clk_i);
    scan_tick_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic seek(input int n);
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      tick();
      hit = (irq_o === 1'b1);
    end
  endtask
  function automatic logic [4:0] col_exp(input logic [2:0] s);
    col_exp = (s < 3'h5) ? ~(5'h01 << s) : 5'h1f;
  endfunction
  task automatic run_order(input logic [2:0] cnt);
    logic [15:0] p;
    p = {1'b0, ord[4], ord[3], ord[2], ord[1], ord[0]};
    wr(IDX_SCAN_CONTROL, 8'h00);
    wr(IDX_COL_ORDER_LOW, p[7:0]);
    wr(IDX_COL_ORDER_HIGH, p[15:8]);
    wr(IDX_KEYPAD_SIZE, {2'b00, 3'h6, cnt});
    wr(IDX_SCAN_CONTROL, 8'h01);
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 7; i++) begin
      `CHK(col_drive_n_o, col_exp(ord[i % cnt]))
      tick();
    end
  endtask
  initial begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    $display("MISMATCH t=%0t run limit reached", $time);
    close_out();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK({col_drive_n_o, irq_o, powerdown_mux_select_o}, 7'h7c)
    chk_rd(IDX_KEYPAD_SIZE, 8'h00);
    chk_rd(IDX_COL_ORDER_LOW, 8'h00);
    chk_rd(IDX_COL_ORDER_HIGH, 8'h00);
    chk_rd(IDX_KP_IRQ_CONTROL, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      wr(IDX_KEYPAD_SIZE, v);
      wr(IDX_COL_ORDER_HIGH, v);
      wr(IDX_KP_IRQ_CONTROL, v);
      wr(16'h0010, v);
      chk_rd(IDX_KEYPAD_SIZE, v & KEYPAD_SIZE_MASK);
      chk_rd(IDX_COL_ORDER_HIGH, v & COL_ORDER_HIGH_MASK);
      chk_rd(IDX_KP_IRQ_CONTROL, v & 8'h82);
      chk_rd(16'h0010, 8'h00);
      `CHK(powerdown_mux_select_o, v[7])
      `CHK(col_drive_n_o, 5'h1f)
    end
    // Bypass: firmware drives columns 1 and 3 itself
    wr(IDX_SCAN_CONTROL, 8'h14);
    wr(IDX_KEYPAD_SIZE, 8'h2d);
    tick();
    `CHK(col_drive_n_o, 5'h15)
    krow <= 3'h2;
    kcol <= 3'h3;
    press <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk_rd(IDX_SCAN_CONTROL, 8'h94);
    chk_rd(IDX_SCAN_CONTROL, 8'h14);
    // The bypass press also raised the keypad flag; reading it here clears it
    chk_rd(IDX_KP_IRQ_CONTROL, (v & 8'h82) | 8'h01);
    press <= 1'b0;
    ord = '{3'h1, 3'h7, 3'h4, 3'h3, 3'h0};
    run_order(3'h3);
    ord = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    run_order(3'h5);
    wr(IDX_KP_IRQ_CONTROL, 8'h02);
    wr(IDX_IRQ_STATUS, 8'h03);
    // Five rows only, so the press on the sixth row must go unseen
    wr(IDX_KEYPAD_SIZE, 8'h2d);
    krow <= 3'h5;
    press <= 1'b1;
    seek(8);
    `CHK(hit, 1'b0)
    wr(IDX_KEYPAD_SIZE, 8'h35);
    seek(8);
    `CHK(hit, 1'b1)
    chk_rd(IDX_KEY_LOCATION, 8'h2b);
    chk_rd(IDX_KP_IRQ_CONTROL, 8'h03);
    chk_rd(IDX_KP_IRQ_CONTROL, 8'h02);
    chk_rd(IDX_SCAN_CONTROL, 8'h81);
    chk_rd(IDX_SCAN_CONTROL, 8'h01);
    `CHK(irq_o, 1'b0)
    // Reload the order as an interrupt handler would
    wr(IDX_COL_ORDER_LOW, 8'h88);
    wr(IDX_COL_ORDER_HIGH, 8'h46);
    press <= 1'b0;
    tick();
    chk_rd(IDX_IRQ_STATUS, 8'h03);
    wr(IDX_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    wr(IDX_IRQ_STATUS, 8'h03);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    chk_rd(IDX_IRQ_STATUS, 8'h00);
    wr(IDX_KP_IRQ_CONTROL, 8'h00);
    wr(IDX_IRQ_MASK, 8'h00);
    krow <= 3'h0;
    kcol <= 3'h0;
    press <= 1'b1;
    seek(8);
    `CHK(hit, 1'b0)
    chk_rd(IDX_KP_IRQ_CONTROL, 8'h01);
    close_out();
  end
endmodule
